/* File: rtl/mscc_top.v */
// Modem configuration bank: correlation threshold, offset filter mode, phase,
// transmit/receive test paths, clear-channel threshold and strength estimate,
// and the frame sync pattern with its transmit/detect logic.
// Assumes a decoded register port (one access per strobe), symbol and bit
// strobes from the modem datapath, all synchronous to clk_i.
`timescale 1ns/100ps
`include "mscc_consts.vh"

module mscc_top (
	// Clock and reset
	input wire clk_i,
	input wire nrst_i,
	// Register port
	input wire [5:0] reg_addr_i,
	input wire [15:0] reg_wdata_i,
	input wire reg_wr_i,
	input wire reg_rd_i,
	output reg [15:0] reg_rdata_o,
	// Demodulator front
	input wire [4:0] corr_value_i,
	input wire preamble_match_i,
	input wire frame_end_i,
	output wire sfd_search_en_o,
	output wire offset_filter_update_o,
	output wire phase_reverse_o,
	// Transmit path
	input wire tx_bit_strobe_i,
	input wire tx_fifo_bit_i,
	input wire tx_fifo_empty_i,
	input wire tx_serial_i,
	input wire [1:0] tx_sync_index_i,
	output wire tx_fifo_read_o,
	output wire tx_fifo_wrap_o,
	output wire tx_continuous_o,
	output reg tx_underflow_o,
	output reg tx_bit_o,
	output wire [3:0] tx_sync_symbol_o,
	// Receive path
	input wire rx_bit_strobe_i,
	input wire rx_bit_i,
	input wire rx_fifo_full_i,
	input wire rx_symbol_strobe_i,
	input wire [3:0] rx_symbol_i,
	output wire rx_fifo_write_o,
	output wire rx_fifo_wrap_o,
	output wire rx_continuous_o,
	output reg rx_overflow_o,
	output reg rx_serial_data_o,
	output reg rx_serial_valid_o,
	output reg sync_detect_o,
	// Signal strength and clear channel
	input wire rx_enabled_i,
	input wire symbol_tick_i,
	input wire [7:0] strength_sample_i,
	input wire [2:0] clear_channel_hysteresis_i,
	output reg strength_estimate_valid_o,
	output reg clear_channel_o
);

	reg rst_meta_r, rst_sync_r, offset_filter_update_mode_r, phase_reverse_r;
	reg preamble_locked_r, seq_match;
	reg [4:0] correlation_threshold_r;
	reg [1:0] tx_mode_r, rx_mode_r;
	reg [7:0] clear_channel_threshold_r, signal_strength_estimate_r;
	reg [15:0] frame_sync_pattern_r, prn_r, req_list;
	reg [3:0] avg_cnt_r;
	reg [7:0] win_r [0:`MSCC_AVG_DEPTH-1];
	reg [3:0] hist_r [0:3];
	reg [19:0] seq_view;
	reg [10:0] win_sum;
	reg [2:0] req_cnt;
	integer k;
	wire rst_n, prn_fb;
	wire [10:0] avg_full;
	wire [8:0] clear_level, strength_ext, thr_ext;
	genvar g;

	// Reset release through two flops; only the second is used downstream
	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rst_meta_r <= 1'b0;
			rst_sync_r <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_sync_r <= rst_meta_r;
		end
	end
	assign rst_n = rst_sync_r;

	// Register writes
	always @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			correlation_threshold_r <= `MSCC_CORRELATION_THRESHOLD_RST;
			offset_filter_update_mode_r <= 1'b0;
			phase_reverse_r <= 1'b0;
			tx_mode_r <= `MSCC_TX_BUFFERED;
			rx_mode_r <= `MSCC_RX_BUFFERED;
			clear_channel_threshold_r <= `MSCC_CLEAR_CHANNEL_THRESHOLD_RST;
			frame_sync_pattern_r <= `MSCC_SYNC_RST;
		end else if (reg_wr_i) begin
			// modem_control_one bits 15:11 have no storage behind them and the estimate byte is read-only
			case (reg_addr_i)
				`MSCC_ADDR_MODEM_CONTROL_ONE: begin
					correlation_threshold_r <=
						reg_wdata_i[`MSCC_CORRELATION_THRESHOLD_MSB:`MSCC_CORRELATION_THRESHOLD_LSB];
					offset_filter_update_mode_r <= reg_wdata_i[`MSCC_OFFSET_MODE_BIT];
					phase_reverse_r <= reg_wdata_i[`MSCC_PHASE_BIT];
					tx_mode_r <= reg_wdata_i[`MSCC_TX_MODE_MSB:`MSCC_TX_MODE_LSB];
					rx_mode_r <= reg_wdata_i[`MSCC_RX_MODE_MSB:`MSCC_RX_MODE_LSB];
				end
				`MSCC_ADDR_SIGNAL_STRENGTH: clear_channel_threshold_r <= reg_wdata_i[15:8];
				`MSCC_ADDR_FRAME_SYNC_PATTERN: frame_sync_pattern_r <= reg_wdata_i;
				default: ;
			endcase
		end
	end

	// Register reads, registered one cycle after the read strobe
	always @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata_o <= 16'h0000;
		end else if (reg_rd_i) begin
			case (reg_addr_i)
				`MSCC_ADDR_MODEM_CONTROL_ONE: begin
					reg_rdata_o <= {5'h00, correlation_threshold_r, offset_filter_update_mode_r,
						phase_reverse_r, tx_mode_r, rx_mode_r};
				end
				`MSCC_ADDR_SIGNAL_STRENGTH: reg_rdata_o <=
					{clear_channel_threshold_r, signal_strength_estimate_r};
				`MSCC_ADDR_FRAME_SYNC_PATTERN: reg_rdata_o <= frame_sync_pattern_r;
				default: reg_rdata_o <= 16'h0000;
			endcase
		end
	end

	// Demodulator controls
	assign sfd_search_en_o = (corr_value_i >= correlation_threshold_r);
	assign phase_reverse_o = phase_reverse_r;

	// Preamble lock holds until the frame ends
	always @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			preamble_locked_r <= 1'b0;
		end else if (frame_end_i) begin
			preamble_locked_r <= 1'b0;
		end else if (preamble_match_i) begin
			preamble_locked_r <= 1'b1;
		end
	end
	assign offset_filter_update_o = offset_filter_update_mode_r |
		~(preamble_locked_r | preamble_match_i);

	// Transmit path selection
	assign tx_fifo_read_o = tx_bit_strobe_i &
		((tx_mode_r == `MSCC_TX_BUFFERED) | (tx_mode_r == `MSCC_TX_LOOPING));
	assign tx_fifo_wrap_o = (tx_mode_r == `MSCC_TX_LOOPING);
	assign tx_continuous_o = (tx_mode_r != `MSCC_TX_BUFFERED);
	assign prn_fb = prn_r[15];

	always @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			tx_bit_o <= 1'b0;
			tx_underflow_o <= 1'b0;
			prn_r <= `MSCC_PRN_SEED;
		end else begin
			// Looping mode never reports underflow
			tx_underflow_o <= tx_bit_strobe_i & tx_fifo_empty_i &
				(tx_mode_r == `MSCC_TX_BUFFERED);
			if (tx_bit_strobe_i) begin
				case (tx_mode_r)
					`MSCC_TX_SERIAL: tx_bit_o <= tx_serial_i;
					`MSCC_TX_RANDOM: tx_bit_o <= prn_fb;
					default: tx_bit_o <= tx_fifo_bit_i;
				endcase
				if (tx_mode_r == `MSCC_TX_RANDOM) begin
					// CRC-16 register stepped once per transmit bit strobe as the random source
					prn_r <= {prn_r[14:12], prn_r[11] ^ prn_fb, prn_r[10:5],
						prn_r[4] ^ prn_fb, prn_r[3:0], prn_fb};
				end
			end
		end
	end

	// Transmit sync symbols: F nibbles go out as zero symbols
	assign tx_sync_symbol_o =
		(frame_sync_pattern_r[tx_sync_index_i*4 +: 4] == `MSCC_SKIP_NIBBLE) ?
		`MSCC_ZERO_SYMBOL : frame_sync_pattern_r[tx_sync_index_i*4 +: 4];

	// Receive path selection; the reserved mode writes nothing and drives nothing
	assign rx_fifo_write_o = rx_bit_strobe_i &
		((rx_mode_r == `MSCC_RX_BUFFERED) | (rx_mode_r == `MSCC_RX_LOOPING));
	assign rx_fifo_wrap_o = (rx_mode_r == `MSCC_RX_LOOPING);
	assign rx_continuous_o = (rx_mode_r == `MSCC_RX_SERIAL) |
		(rx_mode_r == `MSCC_RX_LOOPING);

	always @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			rx_serial_data_o <= 1'b0;
			rx_serial_valid_o <= 1'b0;
			rx_overflow_o <= 1'b0;
		end else begin
			rx_overflow_o <= rx_bit_strobe_i & rx_fifo_full_i &
				(rx_mode_r == `MSCC_RX_BUFFERED);
			rx_serial_valid_o <= rx_bit_strobe_i & (rx_mode_r == `MSCC_RX_SERIAL);
			if (rx_bit_strobe_i && rx_mode_r == `MSCC_RX_SERIAL) begin
				rx_serial_data_o <= rx_bit_i;
			end
		end
	end

	// Received symbol history, newest at index 0
	generate
		for (g = 0; g < 4; g = g + 1) begin : g_hist
			always @(posedge clk_i or negedge rst_n) begin
				if (!rst_n) begin
					hist_r[g] <= 4'hF;
				end else if (rx_symbol_strobe_i) begin
					hist_r[g] <= (g == 0) ? rx_symbol_i : hist_r[(g == 0) ? 0 : g - 1];
				end
			end
		end
	endgenerate

	// Compact the required nibbles, least significant first, then compare them
	// against the history plus the symbol arriving now, so the detect pulse
	// follows the completing strobe; one zero symbol must lead the first one
	always @* begin
		seq_view = {hist_r[3], hist_r[2], hist_r[1], hist_r[0], rx_symbol_i};
		req_list = 16'h0000;
		req_cnt = 3'h0;
		seq_match = 1'b1;
		for (k = 0; k < 4; k = k + 1) begin
			if (frame_sync_pattern_r[k*4 +: 4] != `MSCC_SKIP_NIBBLE) begin
				req_list[req_cnt*4 +: 4] = frame_sync_pattern_r[k*4 +: 4];
				req_cnt = req_cnt + 3'h1;
			end
		end
		for (k = 0; k < 4; k = k + 1) begin
			if (k < req_cnt && seq_view[(req_cnt - 1 - k)*4 +: 4] != req_list[k*4 +: 4]) begin
				seq_match = 1'b0;
			end
		end
		if (seq_view[req_cnt*4 +: 4] != `MSCC_ZERO_SYMBOL) begin
			seq_match = 1'b0;
		end
	end

	always @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			sync_detect_o <= 1'b0;
		end else begin
			// Matches only count while the correlator allows the search
			sync_detect_o <= rx_symbol_strobe_i & seq_match & sfd_search_en_o;
		end
	end

	// Strength averaging window, one sample per symbol tick
	generate
		for (g = 0; g < `MSCC_AVG_DEPTH; g = g + 1) begin : g_win
			always @(posedge clk_i or negedge rst_n) begin
				if (!rst_n) begin
					win_r[g] <= 8'h00;
				end else if (rx_enabled_i && symbol_tick_i) begin
					win_r[g] <= (g == 0) ? strength_sample_i : win_r[(g == 0) ? 0 : g - 1];
				end
			end
		end
	endgenerate

	always @* begin
		win_sum = 11'h000;
		for (k = 0; k < `MSCC_AVG_DEPTH; k = k + 1) begin
			win_sum = win_sum + {{3{win_r[k][7]}}, win_r[k]};
		end
	end
	assign avg_full = $signed(win_sum) >>> `MSCC_AVG_SHIFT;

	always @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			avg_cnt_r <= 4'h0;
			strength_estimate_valid_o <= 1'b0;
			signal_strength_estimate_r <= `MSCC_STRENGTH_RST;
		end else if (!rx_enabled_i) begin
			// Leaving receive discards the window; estimate reads invalid again
			avg_cnt_r <= 4'h0;
			strength_estimate_valid_o <= 1'b0;
			signal_strength_estimate_r <= `MSCC_STRENGTH_RST;
		end else begin
			if (symbol_tick_i && avg_cnt_r != `MSCC_AVG_CNT_MAX) begin
				avg_cnt_r <= avg_cnt_r + 4'h1;
			end
			strength_estimate_valid_o <= (avg_cnt_r == `MSCC_AVG_CNT_MAX);
			if (avg_cnt_r == `MSCC_AVG_CNT_MAX) begin
				signal_strength_estimate_r <= avg_full[7:0];
			end
		end
	end

	// Clear channel with hysteresis: set below threshold minus hysteresis,
	// cleared at or above threshold, held in between
	assign strength_ext = {signal_strength_estimate_r[7], signal_strength_estimate_r};
	assign thr_ext = {clear_channel_threshold_r[7], clear_channel_threshold_r};
	assign clear_level = thr_ext - {6'h00, clear_channel_hysteresis_i};

	always @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			clear_channel_o <= 1'b0;
		end else if (!strength_estimate_valid_o) begin
			clear_channel_o <= 1'b0;
		end else if ($signed(strength_ext) < $signed(clear_level)) begin
			clear_channel_o <= 1'b1;
		end else if ($signed(strength_ext) >= $signed(thr_ext)) begin
			clear_channel_o <= 1'b0;
		end
	end
endmodule // mscc_top

/* File: rtl/mscc_consts.vh */
// Constants for the modem sync / clear-channel configuration bank.
// Included by rtl/mscc_top.v; holds definitions only.
`ifndef MSCC_CONSTS_VH
`define MSCC_CONSTS_VH

// Register addresses on the decoded register port
`define MSCC_ADDR_MODEM_CONTROL_ONE 6'h12
`define MSCC_ADDR_SIGNAL_STRENGTH 6'h13
`define MSCC_ADDR_FRAME_SYNC_PATTERN 6'h14

// modem_control_one fields
`define MSCC_CORRELATION_THRESHOLD_MSB 10
`define MSCC_CORRELATION_THRESHOLD_LSB 6
`define MSCC_OFFSET_MODE_BIT 5
`define MSCC_PHASE_BIT 4
`define MSCC_TX_MODE_MSB 3
`define MSCC_TX_MODE_LSB 2
`define MSCC_RX_MODE_MSB 1
`define MSCC_RX_MODE_LSB 0
`define MSCC_CTRL_USED_MSB 10

// Reset values
`define MSCC_CORRELATION_THRESHOLD_RST 5'h14
`define MSCC_CLEAR_CHANNEL_THRESHOLD_RST 8'hE0
`define MSCC_STRENGTH_RST 8'h80
`define MSCC_SYNC_RST 16'hA70F

// Test-mode encodings
`define MSCC_TX_BUFFERED 2'h0
`define MSCC_TX_SERIAL 2'h1
`define MSCC_TX_LOOPING 2'h2
`define MSCC_TX_RANDOM 2'h3
`define MSCC_RX_BUFFERED 2'h0
`define MSCC_RX_SERIAL 2'h1
`define MSCC_RX_LOOPING 2'h2

// Sync nibble handling
`define MSCC_SKIP_NIBBLE 4'hF
`define MSCC_ZERO_SYMBOL 4'h0

// Strength averaging depth in symbol periods
`define MSCC_AVG_DEPTH 8
`define MSCC_AVG_SHIFT 3
`define MSCC_AVG_CNT_MAX 4'h8

// Pseudo-random generator (CRC-16 polynomial taps) seed
`define MSCC_PRN_SEED 16'hFFFF

`endif

/* File: test/mscc_top_properties.sv */
// Concurrent checks for the modem configuration bank, top ports only.
// Assumes one clock domain and the active-low reset input.
`timescale 1ns/100ps
module mscc_props (
	// Clock, reset and register port
	input wire clk_i,
	input wire nrst_i,
	input wire reg_wr_i,
	input wire [5:0] reg_addr_i,
	// Transmit path
	input wire tx_bit_strobe_i,
	input wire tx_fifo_empty_i,
	input wire tx_fifo_read_o,
	input wire tx_fifo_wrap_o,
	input wire tx_continuous_o,
	input wire tx_underflow_o,
	// Receive path
	input wire rx_bit_strobe_i,
	input wire rx_bit_i,
	input wire rx_fifo_write_o,
	input wire rx_fifo_wrap_o,
	input wire rx_continuous_o,
	input wire rx_serial_data_o,
	input wire rx_serial_valid_o,
	input wire rx_symbol_strobe_i,
	input wire sync_detect_o,
	// Demodulator controls
	input wire sfd_search_en_o,
	input wire phase_reverse_o,
	input wire preamble_match_i,
	input wire offset_filter_update_o,
	// Signal strength and clear channel
	input wire rx_enabled_i,
	input wire symbol_tick_i,
	input wire strength_estimate_valid_o,
	input wire clear_channel_o
);
	reg [3:0] tick_r;
	// Counts enabled symbol ticks; saturates so it never wraps back below eight
	always @(posedge clk_i or negedge nrst_i)
		if (!nrst_i) tick_r <= 4'h0;
		else if (!rx_enabled_i) tick_r <= 4'h0;
		else if (symbol_tick_i && tick_r != 4'hF) tick_r <= tick_r + 4'h1;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	a_tx_read_mode: assert property (
		tx_fifo_read_o == (tx_bit_strobe_i && (!tx_continuous_o || tx_fifo_wrap_o)))
		else $error("transmit buffer read wrong");
	a_tx_underflow: assert property (tx_bit_strobe_i && tx_fifo_empty_i |=>
		tx_underflow_o == !$past(tx_continuous_o)) else $error("underflow wrong");
	a_rx_write_mode: assert property (rx_bit_strobe_i && rx_continuous_o |->
		rx_fifo_write_o == rx_fifo_wrap_o) else $error("receive buffer write wrong");
	a_rx_serial_out: assert property (
		rx_bit_strobe_i && rx_continuous_o && !rx_fifo_wrap_o |=>
		rx_serial_valid_o && rx_serial_data_o == $past(rx_bit_i)) else $error("serial out wrong");
	a_clear_invalid: assert property (
		!strength_estimate_valid_o ##1 !strength_estimate_valid_o |-> !clear_channel_o)
		else $error("clear channel while invalid");
	a_valid_after_eight: assert property (
		$rose(strength_estimate_valid_o) |-> tick_r >= 4'h8) else $error("valid too early");
	a_phase_by_write: assert property ($changed(phase_reverse_o) |->
		$past(reg_wr_i) && $past(reg_addr_i) == 6'h12) else $error("phase changed alone");
	a_sync_gate: assert property (sync_detect_o |->
		$past(rx_symbol_strobe_i) && $past(sfd_search_en_o)) else $error("stray sync");
	a_offset_freeze: assert property ($fell(offset_filter_update_o) |->
		preamble_match_i || $past(reg_wr_i)) else $error("filter froze alone");
	c_sync: cover property (sync_detect_o);
	c_valid: cover property ($rose(strength_estimate_valid_o));
	c_clear: cover property ($rose(clear_channel_o));
endmodule // mscc_props

bind mscc_top mscc_props u_props (.*);

/* File: test/mscc_host.sv */
// Host model: drives the register port on falling clock edges.
// Assumes the bench owns the clock and has released reset.
`timescale 1ns/100ps
module mscc_host (
	input wire clk_i,
	input wire [15:0] rdata_i,
	output reg [5:0] addr_o = 6'h00,
	output reg [15:0] wdata_o = 16'h0000,
	output reg wr_o = 1'b0,
	output reg rd_o = 1'b0
);
	// Random idle gaps make the host sometimes prompt, sometimes slow
	task wr(input [5:0] a, input [15:0] d);
		repeat (1 + $urandom % 3) @(negedge clk_i);
		addr_o = a;
		wdata_o = (a == 6'h12) ? (d & 16'h07FF) : d;
		wr_o = 1'b1;
		@(negedge clk_i);
		wr_o = 1'b0;
		wdata_o = ~wdata_o;
	endtask
	task rd(input [5:0] a, output [15:0] d);
		repeat (1 + $urandom % 3) @(negedge clk_i);
		addr_o = a;
		rd_o = 1'b1;
		@(negedge clk_i);
		rd_o = 1'b0;
		@(negedge clk_i);
		d = rdata_i;
	endtask
endmodule // mscc_host

/* File: test/mscc_top_tb_top.sv */
// Self-checking bench for the modem configuration bank.
// Assumes the host model on the register port; other inputs driven here.
`timescale 1ns/100ps
module mscc_top_tb_top;
	reg clk_i = 1'b0;
	reg nrst_i = 1'b0;
	wire [5:0] reg_addr_i;
	wire [15:0] reg_wdata_i, reg_rdata_o;
	wire reg_wr_i, reg_rd_i, tx_bit_o, sync_detect_o, clear_channel_o;
	wire sfd_search_en_o, offset_filter_update_o, phase_reverse_o, tx_underflow_o;
	wire tx_fifo_read_o, tx_fifo_wrap_o, tx_continuous_o, rx_fifo_write_o, rx_overflow_o;
	wire rx_fifo_wrap_o, rx_continuous_o, rx_serial_data_o, rx_serial_valid_o;
	wire strength_estimate_valid_o;
	wire [3:0] tx_sync_symbol_o;
	reg preamble_match_i, frame_end_i, tx_bit_strobe_i, tx_fifo_bit_i, tx_fifo_empty_i;
	reg tx_serial_i, rx_bit_strobe_i, rx_bit_i, rx_fifo_full_i, rx_symbol_strobe_i;
	reg rx_enabled_i, symbol_tick_i;
	reg [4:0] corr_value_i;
	reg [1:0] tx_sync_index_i;
	reg [3:0] rx_symbol_i;
	reg [7:0] strength_sample_i, t;
	reg [2:0] clear_channel_hysteresis_i;
	reg [15:0] d, r;
	reg [15:0] prn_m = 16'hFFFF;
	int error_cnt = 0, samples_checked = 0, i, m, s, e;

	always #5 clk_i = ~clk_i;
	mscc_top u_dut (.*);
	mscc_host u_host (.clk_i(clk_i), .rdata_i(reg_rdata_o), .addr_o(reg_addr_i),
		.wdata_o(reg_wdata_i), .wr_o(reg_wr_i), .rd_o(reg_rd_i));

	task chk(input [15:0] seen, input [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	// CRC-16 generator step, polynomial 0x1021, shifting towards the MSB
	function automatic [15:0] prn_step(input [15:0] p);
		prn_step = {p[14:0], 1'b0} ^ (p[15] ? 16'h1021 : 16'h0000);
	endfunction
	task cyc(int n);
		repeat (n) @(negedge clk_i);
	endtask
	task print_verdict;
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Four symbols, first in the low nibble; detect expected after the last
	task sync_seq(input [15:0] q, input x);
		for (int k = 0; k < 4; k++) begin
			rx_symbol_i = q[4*k +: 4];
			rx_symbol_strobe_i = 1'b1;
			cyc(1);
			rx_symbol_strobe_i = 1'b0;
			chk(sync_detect_o, k == 3 && x);
			cyc(1);
		end
	endtask

	initial begin
		#100000;
		error_cnt++;
		print_verdict;
	end

	initial begin
		{preamble_match_i, frame_end_i, tx_bit_strobe_i, tx_fifo_bit_i, tx_serial_i} = 5'h00;
		{rx_bit_strobe_i, rx_bit_i, rx_fifo_full_i, rx_symbol_strobe_i} = 4'h0;
		{rx_enabled_i, symbol_tick_i, corr_value_i, tx_sync_index_i, rx_symbol_i} = 13'h0000;
		{strength_sample_i, clear_channel_hysteresis_i} = 11'h000;
		tx_fifo_empty_i = 1'b1;
		void'($urandom(38));
		cyc(16);
		nrst_i = 1'b1;
		cyc(3);
		u_host.rd(6'h12, r);
		chk(r, 16'h0500);
		u_host.rd(6'h13, r);
		chk(r, 16'hE080);
		u_host.rd(6'h14, r);
		chk(r, 16'hA70F);
		u_host.rd(6'h15, r);
		chk(r, 16'h0000);
		for (i = 0; i < 8; i++) begin
			d = $urandom;
			d[3:0] = 4'(i * 5);
			corr_value_i = (i < 2) ? d[10:6] : 5'($urandom);
			u_host.wr(6'h12, d);
			u_host.rd(6'h12, r);
			chk(r, d & 16'h07FF);
			chk(sfd_search_en_o, corr_value_i >= d[10:6]);
			chk(phase_reverse_o, d[4]);
			chk(tx_continuous_o, d[3:2] != 2'h0);
			chk(tx_fifo_wrap_o, d[3:2] == 2'h2);
			chk(rx_continuous_o, d[1:0] == 2'h1 || d[1:0] == 2'h2);
			chk(rx_fifo_wrap_o, d[1:0] == 2'h2);
			u_host.wr(6'h13, d);
			u_host.rd(6'h13, r);
			chk(r, {d[15:8], 8'h80});
		end
		for (m = 0; m < 2; m++) begin
			u_host.wr(6'h12, {10'h000, m[0], 5'h00});
			preamble_match_i = 1'b1;
			cyc(1);
			preamble_match_i = 1'b0;
			cyc(1);
			chk(offset_filter_update_o, m);
			frame_end_i = 1'b1;
			cyc(1);
			frame_end_i = 1'b0;
			cyc(1);
			chk(offset_filter_update_o, 1'b1);
		end
		for (m = 0; m < 4; m++) begin
			u_host.wr(6'h12, {12'h000, m[1:0], m[1:0]});
			for (i = 0; i < 3; i++) begin
				tx_fifo_bit_i = $urandom;
				tx_serial_i = !tx_fifo_bit_i;
				rx_bit_i = $urandom;
				tx_fifo_empty_i = (i != 1);
				rx_fifo_full_i = (i != 2);
				tx_bit_strobe_i = 1'b1;
				rx_bit_strobe_i = 1'b1;
				#1 chk(rx_fifo_write_o, m == 0 || m == 2);
				cyc(1);
				tx_bit_strobe_i = 1'b0;
				rx_bit_strobe_i = 1'b0;
				chk(tx_underflow_o, m == 0 && tx_fifo_empty_i);
				chk(rx_overflow_o, m == 0 && rx_fifo_full_i);
				chk(rx_serial_valid_o, m == 1);
				if (m == 1) chk(rx_serial_data_o, rx_bit_i);
				if (m == 3) begin
					chk(tx_bit_o, prn_m[15]);
					prn_m = prn_step(prn_m);
				end else begin
					chk(tx_bit_o, m == 1 ? tx_serial_i : tx_fifo_bit_i);
				end
				cyc(1);
			end
		end
		d = $urandom;
		d[7:4] = 4'hF;
		u_host.wr(6'h14, d);
		for (i = 0; i < 4; i++) begin
			tx_sync_index_i = i[1:0];
			cyc(1);
			chk(tx_sync_symbol_o, d[4*i +: 4] == 4'hF ? 4'h0 : d[4*i +: 4]);
		end
		u_host.wr(6'h14, 16'hA70F);
		u_host.wr(6'h12, 16'h0280);
		corr_value_i = 5'h1F;
		sync_seq(16'hA700, 1'b1);
		sync_seq(16'hA705, 1'b0);
		corr_value_i = 5'h05;
		sync_seq(16'hA700, 1'b0);
		s = $urandom_range(40, 0) - 100;
		e = s + 3;
		clear_channel_hysteresis_i = 3'(1 + $urandom % 7);
		t = 8'(e + clear_channel_hysteresis_i + 1);
		u_host.wr(6'h13, {t, 8'h00});
		rx_enabled_i = 1'b1;
		for (i = 0; i < 8; i++) begin
			chk(strength_estimate_valid_o, 1'b0);
			strength_sample_i = 8'(s + i);
			symbol_tick_i = 1'b1;
			cyc(1);
			symbol_tick_i = 1'b0;
			cyc(1);
		end
		chk(strength_estimate_valid_o, 1'b1);
		u_host.rd(6'h13, r);
		chk(r, {t, 8'(e)});
		// Below the hysteresis band, inside it, at the threshold, inside again; the band holds the last state
		for (i = 0; i < 4; i++) begin
			t = 8'(e + ((i == 0) ? clear_channel_hysteresis_i + 1 : (i != 2)));
			u_host.wr(6'h13, {t, 8'h00});
			cyc(2);
			chk(clear_channel_o, i < 2);
		end
		rx_enabled_i = 1'b0;
		cyc(2);
		chk(strength_estimate_valid_o, 1'b0);
		chk(clear_channel_o, 1'b0);
		u_host.rd(6'h13, r);
		chk(r[7:0], 8'h80);
		print_verdict;
	end
endmodule // mscc_top_tb_top
